// ### pkg/rpsel_pkg.sv
// Package with offsets, field layout, reset values and carrier types of the pin select block
package rpsel_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int ADDR_W       = 6;
   localparam int DATA_W       = 32;
   localparam int FIELD_W      = 5;
   localparam int NUM_IN_SEL   = 6;
   localparam int NUM_IN_REGS  = 4;
   localparam int NUM_OUT_PINS = 10;
   localparam int NUM_REGS     = 9;
   localparam int NUM_FUNCS    = 32;
   localparam int REG_W        = 16;

   // ****************************************************************
   // Register byte offsets, one aligned word each
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_SPI1_CLOCK_DATA   = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_SPI1_SLAVE_SELECT = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_SPI2_CLOCK_DATA   = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_SPI2_SLAVE_SELECT = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_OUT_MAP_PINS_0_1  = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_OUT_MAP_PINS_2_3  = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_OUT_MAP_PINS_4_5  = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_OUT_MAP_PINS_6_7  = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_OUT_MAP_PINS_8_9  = 6'h20;
   localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
      OFS_SPI1_CLOCK_DATA, OFS_SPI1_SLAVE_SELECT, OFS_SPI2_CLOCK_DATA,
      OFS_SPI2_SLAVE_SELECT, OFS_OUT_MAP_PINS_0_1, OFS_OUT_MAP_PINS_2_3,
      OFS_OUT_MAP_PINS_4_5, OFS_OUT_MAP_PINS_6_7, OFS_OUT_MAP_PINS_8_9};

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int HI_LSB = 8;
   localparam int LO_LSB = 0;
   localparam logic [FIELD_W-1:0] IN_SEL_RESET  = 5'h1F;
   localparam logic [FIELD_W-1:0] OUT_MAP_RESET = 5'h00;
   localparam logic [FIELD_W-1:0] FUNC_PORT     = 5'h00;

   // Input selections: 0 port1 clock, 1 port1 data, 2 port1 slave select,
   // 3 port2 clock, 4 port2 data, 5 port2 slave select
   localparam int IN_SEL_REG [NUM_IN_SEL] = '{0, 0, 1, 2, 2, 3};
   localparam int IN_SEL_LSB [NUM_IN_SEL] = '{HI_LSB, LO_LSB, LO_LSB, HI_LSB, LO_LSB, LO_LSB};

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic clock_input;
      logic data_input;
      logic slave_select_input;
   } rpsel_spi_in_s;

   typedef struct packed {
      logic [NUM_FUNCS-1:0] drive;
      logic [NUM_FUNCS-1:0] enable;
   } rpsel_periph_out_s;

   typedef struct packed {
      logic [NUM_OUT_PINS-1:0] out;
      logic [NUM_OUT_PINS-1:0] oe;
   } rpsel_pin_drive_s;

endpackage

// ### hdl/rpsel_in_route.sv
// One input selection: picks a remappable pin and registers it for a peripheral input
module rpsel_in_route #(
   parameter int   NUM_PINS   = 26,
   parameter logic IDLE_LEVEL = 1'b1
) (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            reset_n,
   // Pins and selection
   input  wire logic [NUM_PINS-1:0]             pin_in,
   input  wire logic [rpsel_pkg::FIELD_W-1:0]   pin_select,
   // Routed level
   output logic                                 routed_r
);

   logic in_range;
   logic picked;

   // Codes beyond the last pin select nothing; the input then idles
   assign in_range = int'(pin_select) < NUM_PINS;
   assign picked   = in_range ? pin_in[pin_select] : IDLE_LEVEL;

   // Registered so the peripheral never sees a glitch while software remaps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         routed_r <= IDLE_LEVEL;
      end else begin
         routed_r <= picked;
      end
   end

endmodule

// ### hdl/rpsel_out_route.sv
// One remappable output pin: peripheral function or ordinary port control
module rpsel_out_route (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              reset_n,
   // Function number held by the mapping field
   input  wire logic [rpsel_pkg::FIELD_W-1:0]     func,
   // Peripheral outputs and port control for this pin
   input  wire logic [rpsel_pkg::NUM_FUNCS-1:0]   periph_drive,
   input  wire logic [rpsel_pkg::NUM_FUNCS-1:0]   periph_enable,
   input  wire logic                              port_out,
   input  wire logic                              port_oe,
   // Pin drive
   output logic                                   pin_out_r,
   output logic                                   pin_oe_r
);

   logic use_port;
   logic out_nxt;
   logic oe_nxt;

   // Function zero hands the pin back to its port latch and tristate
   assign use_port = (func == rpsel_pkg::FUNC_PORT);
   assign out_nxt  = use_port ? port_out : periph_drive[func];
   assign oe_nxt   = use_port ? port_oe : periph_enable[func];

   // Pin released (not driven) during reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_r <= 1'b0;
         pin_oe_r  <= 1'b0;
      end else begin
         pin_out_r <= out_nxt;
         pin_oe_r  <= oe_nxt;
      end
   end

endmodule

// ### hdl/rpsel_spi_pin_map.sv
// Pin select matrix slice: serial port input selections and output maps for pins 0 to 9
//
// Notes on behaviour
// RL1 - Port 1 clock input follows the pin chosen by bits 12-8 of its register.
// RL2 - Port 1 data input follows the pin chosen by bits 4-0 of that register.
// RL3 - Port 1 slave select follows bits 4-0 of its own register; 15-5 absent.
// RL4 - Port 2 clock input follows the pin chosen by bits 12-8 of its register.
// RL5 - Port 2 data input follows the pin chosen by bits 4-0 of that register.
// RL6 - Port 2 slave select follows bits 4-0 of its own register; 15-5 absent.
// RL7 - Input selection fields are read/write and reset to all ones.
// RL8 - Output mapping fields are read/write and reset to all zeros.
// RL9 - Unimplemented bits of every select register always read as zero.
// RL10 - Output field holds a function number; that peripheral output drives the pin.
// RL11 - Each output register packs two pins: odd in 12-8, even in 4-0.
// RL12 - Output field zero leaves the pin under ordinary port control.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
module rpsel_spi_pin_map #(
   parameter int   NUM_IN_PINS = 26,
   parameter logic IDLE_LEVEL  = 1'b1
) (
   // Clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 reset_n,
   // Avalon-MM slave
   input  wire logic [rpsel_pkg::ADDR_W-1:0]         avs_address,
   input  wire logic                                 avs_read,
   input  wire logic                                 avs_write,
   input  wire logic [3:0]                           avs_byteenable,
   input  wire logic [rpsel_pkg::DATA_W-1:0]         avs_writedata,
   output logic      [rpsel_pkg::DATA_W-1:0]         avs_readdata,
   output logic                                      avs_waitrequest,
   // Remappable pins
   input  wire logic [NUM_IN_PINS-1:0]               pin_in,
   output logic      [rpsel_pkg::NUM_OUT_PINS-1:0]   pin_out,
   output logic      [rpsel_pkg::NUM_OUT_PINS-1:0]   pin_oe,
   // Peripheral output bus and ordinary port control
   input  wire rpsel_pkg::rpsel_periph_out_s         periph_out,
   input  wire rpsel_pkg::rpsel_pin_drive_s          port_ctl,
   // Serial port inputs
   output rpsel_pkg::rpsel_spi_in_s                  port1_in,
   output rpsel_pkg::rpsel_spi_in_s                  port2_in
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam int NIS = rpsel_pkg::NUM_IN_SEL;
   localparam int NOP = rpsel_pkg::NUM_OUT_PINS;
   localparam int NRG = rpsel_pkg::NUM_REGS;
   localparam int NIR = rpsel_pkg::NUM_IN_REGS;

   logic [rpsel_pkg::FIELD_W-1:0] in_sel_r  [NIS];
   logic [rpsel_pkg::FIELD_W-1:0] out_map_r [NOP];
   logic [rpsel_pkg::REG_W-1:0]   reg_img   [NRG];
   logic [NRG-1:0]                reg_hit;
   logic [NIS-1:0]                we_in;
   logic [NOP-1:0]                we_out;
   logic [NIS-1:0]                routed;
   logic [rpsel_pkg::REG_W-1:0]   rd_word;
   logic [rpsel_pkg::DATA_W-1:0]  readdata_r;
   logic                          ack_r;
   logic                          req;
   logic                          wr_go;
   logic                          rd_load;
   logic                          first_r;

   // Readable names for the six input selection fields
   wire [rpsel_pkg::FIELD_W-1:0] port1_clock_pin_select      = in_sel_r[0];
   wire [rpsel_pkg::FIELD_W-1:0] port1_data_in_pin_select    = in_sel_r[1];
   wire [rpsel_pkg::FIELD_W-1:0] port1_slave_sel_pin_select  = in_sel_r[2];
   wire [rpsel_pkg::FIELD_W-1:0] port2_clock_pin_select      = in_sel_r[3];
   wire [rpsel_pkg::FIELD_W-1:0] port2_data_in_pin_select    = in_sel_r[4];
   wire [rpsel_pkg::FIELD_W-1:0] port2_slave_sel_pin_select  = in_sel_r[5];

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   // One wait state on every access: the first cycle of a request looks
   // up the read word, the second cycle completes it.
   // A write lands only in the second cycle, so a request dropped
   // early changes nothing.
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_go           = avs_write & ack_r;
   assign rd_load         = avs_read & ~ack_r;
   assign avs_readdata    = readdata_r;

   // Acknowledge toggles so back-to-back requests each get their wait state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read word registered one cycle ahead of the completing edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readdata_r <= 32'h0000_0000;
      end else if (rd_load) begin
         readdata_r <= {16'h0000, rd_word};
      end
   end

   // ****************************************************************
   // Address decode and read images
   // ****************************************************************
   // Unmapped and misaligned addresses hit nothing: writes drop, reads give zero
   // Full compare keeps aliases out of the map
   genvar gi;
   generate
      for (gi = 0; gi < NRG; gi++) begin : g_hit
         assign reg_hit[gi] = (avs_address == rpsel_pkg::REG_OFS[gi]);
      end
   endgenerate

   // Input register images, absent bits tied to zero
   assign reg_img[0] = {3'h0, in_sel_r[0], 3'h0, in_sel_r[1]};  // RL9
   assign reg_img[1] = {11'h000, in_sel_r[2]};                   // RL3
   assign reg_img[2] = {3'h0, in_sel_r[3], 3'h0, in_sel_r[4]};  // RL9
   assign reg_img[3] = {11'h000, in_sel_r[5]};                   // RL6

   // Output register images, odd pin high and even pin low
   generate
      for (gi = 0; gi < NOP / 2; gi++) begin : g_out_img
         assign reg_img[NIR + gi] = {3'h0, out_map_r[2*gi+1], 3'h0, out_map_r[2*gi]}; // RL11
      end
   endgenerate

   // Read selection, zero when nothing is hit
   // Offsets are distinct, so at most one hits
   always_comb begin
      rd_word = 16'h0000;
      for (int i = 0; i < NRG; i++) begin
         if (reg_hit[i]) begin
            rd_word = reg_img[i];
         end
      end
   end

   // ****************************************************************
   // Input selection fields
   // ****************************************************************
   // A field is written only when its byte lane is enabled, so a byte
   // write can change one serial line without touching its neighbour.
   // Lanes 2 and 3 hold no field and are ignored
   generate
      for (gi = 0; gi < NIS; gi++) begin : g_in_sel
         localparam int LSB = rpsel_pkg::IN_SEL_LSB[gi];
         assign we_in[gi] = wr_go & reg_hit[rpsel_pkg::IN_SEL_REG[gi]]
                            & avs_byteenable[LSB / 8];

         // Field storage, all ones after reset
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               in_sel_r[gi] <= rpsel_pkg::IN_SEL_RESET;         // RL7
            end else if (we_in[gi]) begin
               in_sel_r[gi] <= avs_writedata[LSB +: rpsel_pkg::FIELD_W]; // RL7
            end
         end

         // Route is registered: one cycle of latency
         rpsel_in_route #(
            .NUM_PINS   (NUM_IN_PINS),
            .IDLE_LEVEL (IDLE_LEVEL)
         ) u_in_route (
            .clk        (clk),
            .reset_n    (reset_n),
            .pin_in     (pin_in),
            .pin_select (in_sel_r[gi]),
            .routed_r   (routed[gi])
         );
      end
   endgenerate

   // Routed levels onto the two serial ports
   assign port1_in.clock_input        = routed[0];  // RL1
   assign port1_in.data_input         = routed[1];  // RL2
   assign port1_in.slave_select_input = routed[2];  // RL3
   assign port2_in.clock_input        = routed[3];  // RL4
   assign port2_in.data_input         = routed[4];  // RL5
   assign port2_in.slave_select_input = routed[5];  // RL6

   // ****************************************************************
   // Output mapping fields
   // ****************************************************************
   // Even pins live in byte lane 0, odd pins in byte lane 1
   // Codes 1 to 31 index the bus, code 0 selects port control; none is illegal
   generate
      for (gi = 0; gi < NOP; gi++) begin : g_out_map
         localparam int LSB = (gi % 2 == 1) ? rpsel_pkg::HI_LSB : rpsel_pkg::LO_LSB;
         assign we_out[gi] = wr_go & reg_hit[NIR + gi / 2] & avs_byteenable[gi % 2]; // RL11

         // Field storage, zero after reset so pins start under port control
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               out_map_r[gi] <= rpsel_pkg::OUT_MAP_RESET;       // RL8
            end else if (we_out[gi]) begin
               out_map_r[gi] <= avs_writedata[LSB +: rpsel_pkg::FIELD_W]; // RL8
            end
         end

         rpsel_out_route u_out_route (
            .clk           (clk),
            .reset_n       (reset_n),
            .func          (out_map_r[gi]),           // RL10
            .periph_drive  (periph_out.drive),
            .periph_enable (periph_out.enable),
            .port_out      (port_ctl.out[gi]),         // RL12
            .port_oe       (port_ctl.oe[gi]),
            .pin_out_r     (pin_out[gi]),
            .pin_oe_r      (pin_oe[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Marks the first edge after reset release
   // Lets reset checks fire once, at the first live edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   // One clock domain; checks sleep in reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Completing edge of an accepted access
   sequence s_wr_done(logic [rpsel_pkg::ADDR_W-1:0] ofs);
      avs_write && !avs_waitrequest && avs_address == ofs;
   endsequence

   sequence s_rd_done(logic [rpsel_pkg::ADDR_W-1:0] ofs);
      avs_read && !avs_waitrequest && avs_address == ofs;
   endsequence

   // Request that must stall exactly one cycle
   sequence s_req_start;
      req && !ack_r;
   endsequence

   // Any selection in range carries that pin to the peripheral one edge
   // later; $past sees pin and code as they stood.
   property p_route(logic [rpsel_pkg::FIELD_W-1:0] sel, logic routed_bit);
      (int'(sel) < NUM_IN_PINS) |=> (routed_bit == $past(pin_in[sel]));
   endproperty

   AST_P1_CLOCK: assert property (p_route(port1_clock_pin_select, port1_in.clock_input)) // RL1
      else $error("port1 clock input does not follow selected pin");
   AST_P1_DATA: assert property (p_route(port1_data_in_pin_select, port1_in.data_input)) // RL2
      else $error("port1 data input does not follow selected pin");
   AST_P1_SS: assert property (p_route(port1_slave_sel_pin_select,                      // RL3
                                       port1_in.slave_select_input))
      else $error("port1 slave select does not follow selected pin");
   AST_P2_CLOCK: assert property (p_route(port2_clock_pin_select, port2_in.clock_input)) // RL4
      else $error("port2 clock input does not follow selected pin");
   AST_P2_DATA: assert property (p_route(port2_data_in_pin_select, port2_in.data_input)) // RL5
      else $error("port2 data input does not follow selected pin");
   AST_P2_SS: assert property (p_route(port2_slave_sel_pin_select,                      // RL6
                                       port2_in.slave_select_input))
      else $error("port2 slave select does not follow selected pin");

   // Codes past the last pin keep each serial input idle, so a
   // peripheral sees a quiet line until software picks a real pin
   generate
      for (gi = 0; gi < NIS; gi++) begin : g_idle_chk
         AST_IN_IDLE: assert property ((int'(in_sel_r[gi]) >= NUM_IN_PINS) |=> // RL7
                                       (routed[gi] == IDLE_LEVEL))
            else $error("serial input not idle past the last pin");
      end
   endgenerate

   AST_IN_RESET: assert property (first_r |-> (in_sel_r[0] == 5'h1F && in_sel_r[1] == 5'h1F // RL7
                                  && in_sel_r[2] == 5'h1F && in_sel_r[3] == 5'h1F
                                  && in_sel_r[4] == 5'h1F && in_sel_r[5] == 5'h1F))
      else $error("input selection not all ones after reset");

   AST_IN_WRITE: assert property (s_wr_done(rpsel_pkg::OFS_SPI1_CLOCK_DATA) // RL7
                                  ##0 avs_byteenable[1]
                                  |=> port1_clock_pin_select == $past(avs_writedata[12:8]))
      else $error("port1 clock selection write lost");

   // A byte write keeps the other lane's field
   AST_LANE_KEEP: assert property (s_wr_done(rpsel_pkg::OFS_SPI1_CLOCK_DATA) // RL7
                                   ##0 !avs_byteenable[1]
                                   |=> $stable(port1_clock_pin_select))
      else $error("port1 clock selection changed with lane off");

   AST_OUT_RESET: assert property (first_r |-> (out_map_r[0] == 5'h00 && out_map_r[9] == 5'h00 // RL8
                                   && pin_oe == 10'h000))
      else $error("output mapping not zero after reset");

   AST_RD_UNIMPL: assert property (avs_read && !avs_waitrequest |-> // RL9
                                   (avs_readdata[31:13] == 19'h0_0000 && avs_readdata[7:5] == 3'h0))
      else $error("unimplemented bits read nonzero");

   AST_RD_SS_UPPER: assert property (s_rd_done(rpsel_pkg::OFS_SPI2_SLAVE_SELECT) |-> // RL9
                                     avs_readdata[31:5] == 27'h000_0000)
      else $error("slave select register upper bits read nonzero");

   AST_RD_SS1_UPPER: assert property (s_rd_done(rpsel_pkg::OFS_SPI1_SLAVE_SELECT) |-> // RL9
                                      avs_readdata[31:5] == 27'h000_0000)
      else $error("port1 slave select upper bits read nonzero");

   // Fields seen at lookup still stand at completion
   AST_RD_IN_FIELDS: assert property (s_rd_done(rpsel_pkg::OFS_SPI1_CLOCK_DATA) |-> // RL7
                                      avs_readdata[12:8] == port1_clock_pin_select
                                      && avs_readdata[4:0] == port1_data_in_pin_select)
      else $error("port1 selections read back wrong");

   AST_RD_OUT_FIELDS: assert property (s_rd_done(rpsel_pkg::OFS_OUT_MAP_PINS_0_1) |-> // RL8
                                       avs_readdata[12:8] == out_map_r[1]
                                       && avs_readdata[4:0] == out_map_r[0])
      else $error("pins 0 and 1 mappings read back wrong");

   AST_OUT_FUNC: assert property ((out_map_r[3] != 5'h00) |=> // RL10
                                  (pin_out[3] == $past(periph_out.drive[out_map_r[3]])
                                   && pin_oe[3] == $past(periph_out.enable[out_map_r[3]])))
      else $error("pin 3 not driven by mapped peripheral output");

   AST_OUT_PACK: assert property (s_wr_done(rpsel_pkg::OFS_OUT_MAP_PINS_8_9) // RL11
                                  ##0 avs_byteenable[1:0] == 2'b11
                                  |=> (out_map_r[9] == $past(avs_writedata[12:8])
                                       && out_map_r[8] == $past(avs_writedata[4:0])))
      else $error("pins 8 and 9 fields not packed as odd high even low");

   AST_OUT_PORT: assert property ((out_map_r[0] == 5'h00) |=> // RL12
                                  (pin_out[0] == $past(port_ctl.out[0])
                                   && pin_oe[0] == $past(port_ctl.oe[0])))
      else $error("pin 0 not under port control with function zero");

   // Every request stalls exactly one cycle
   AST_ONE_WAIT: assert property (s_req_start |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("access did not complete after one wait state");

endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the serial port pin select and output map block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals and design instance
   // ****************************************************************
   logic                                  clk;
   logic                                  reset_n;
   logic [rpsel_pkg::ADDR_W-1:0]          avs_address;
   logic                                  avs_read;
   logic                                  avs_write;
   logic [3:0]                            avs_byteenable;
   logic [rpsel_pkg::DATA_W-1:0]          avs_writedata;
   logic [rpsel_pkg::DATA_W-1:0]          avs_readdata;
   logic                                  avs_waitrequest;
   logic [25:0]                           pin_in;
   logic [rpsel_pkg::NUM_OUT_PINS-1:0]    pin_out;
   logic [rpsel_pkg::NUM_OUT_PINS-1:0]    pin_oe;
   rpsel_pkg::rpsel_periph_out_s          periph_out;
   rpsel_pkg::rpsel_pin_drive_s           port_ctl;
   rpsel_pkg::rpsel_spi_in_s              port1_in;
   rpsel_pkg::rpsel_spi_in_s              port2_in;
   int                                    n_errors;
   int                                    checks_done;
   logic [31:0]                           rd;

   rpsel_spi_pin_map #(.NUM_IN_PINS(26), .IDLE_LEVEL(1'b1)) uut (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out), .port_ctl(port_ctl),
      .port1_in(port1_in), .port2_in(port2_in));

   // 100 MHz system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Closing report, also reached from a bus timeout
   task automatic give_verdict();
      $display("Checks done %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One bus cycle; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         $display("[ERR] waitrequest expected 0 seen stuck");
         give_verdict();
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Power-on values of every field and of the routed signals
   task automatic t_reset_values();
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, rpsel_pkg::REG_OFS[i], 32'h0000_0000);
         chk("reset reg", (i < 4) ? ((i % 2) ? 32'h0000_001F : 32'h0000_1F1F) : 32'h0, rd);
      end
      chk("idle port inputs", 32'h0000_003F, {26'h0, port1_in, port2_in});
      chk("pins under port", {12'h0, port_ctl.out, port_ctl.oe}, {12'h0, pin_out, pin_oe});
   endtask

   // All ones written: only implemented field bits read back; holes ignored
   task automatic t_readback();
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, rpsel_pkg::REG_OFS[i], 32'hFFFF_FFFF);
         bus(1'b0, rpsel_pkg::REG_OFS[i], 32'h0000_0000);
         chk("ones reg", (i == 1 || i == 3) ? 32'h0000_001F : 32'h0000_1F1F, rd);
      end
      bus(1'b1, 6'h24, 32'hFFFF_FFFF);
      bus(1'b0, 6'h24, 32'h0000_0000);
      chk("unmapped read", 32'h0, rd);
      bus(1'b0, 6'h02, 32'h0000_0000);
      chk("misaligned read", 32'h0, rd);
   endtask

   // Each serial input follows only its own selected pin
   task automatic t_input_route();
      int sel [6] = '{3, 7, 25, 0, 12, 20};
      bus(1'b1, rpsel_pkg::OFS_SPI1_CLOCK_DATA, 32'h0000_0307);
      bus(1'b1, rpsel_pkg::OFS_SPI1_SLAVE_SELECT, 32'h0000_0019);
      bus(1'b1, rpsel_pkg::OFS_SPI2_CLOCK_DATA, 32'h0000_000C);
      bus(1'b1, rpsel_pkg::OFS_SPI2_SLAVE_SELECT, 32'h0000_0014);
      avs_byteenable <= 4'h1;
      bus(1'b1, rpsel_pkg::OFS_SPI1_CLOCK_DATA, 32'h0000_1F07);
      avs_byteenable <= 4'hF;
      for (int i = 0; i < 6; i++) begin
         pin_in <= 26'h1 << sel[i];
         repeat (3) @(posedge clk);
         chk("one-hot route", 32'h20 >> i, {26'h0, port1_in, port2_in});
      end
      pin_in <= 26'h3FF_FFFF;
      repeat (3) @(posedge clk);
      chk("all pins high", 32'h3F, {26'h0, port1_in, port2_in});
   endtask

   // Function numbers onto pins 0 to 9, then pins 2 and 3 back to port control
   task automatic t_output_route();
      logic [4:0]  f [10];
      logic [9:0]  eo;
      logic [9:0]  ee;
      for (int n = 0; n < 10; n++)
         f[n] = (n == 9) ? 5'h1F : 5'(n + 1);
      for (int k = 0; k < 5; k++)
         bus(1'b1, rpsel_pkg::REG_OFS[4 + k], {19'h0, f[2*k+1], 3'h0, f[2*k]});
      for (int n = 0; n < 10; n++) begin
         eo[n] = periph_out.drive[f[n]];
         ee[n] = periph_out.enable[f[n]];
      end
      repeat (2) @(posedge clk);
      chk("mapped pins", {12'h0, eo, ee}, {12'h0, pin_out, pin_oe});
      bus(1'b1, rpsel_pkg::OFS_OUT_MAP_PINS_2_3, 32'h0000_0000);
      periph_out <= ~periph_out;
      port_ctl   <= ~port_ctl;
      repeat (2) @(posedge clk);
      eo = ~eo;
      ee = ~ee;
      eo[3:2] = port_ctl.out[3:2];
      ee[3:2] = port_ctl.oe[3:2];
      chk("unmapped pins", {12'h0, eo, ee}, {12'h0, pin_out, pin_oe});
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      n_errors       = 0;
      checks_done    = 0;
      reset_n        = 1'b0;
      avs_address    = 6'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_byteenable = 4'hF;
      avs_writedata  = 32'h0000_0000;
      pin_in         = 26'h000_0000;
      periph_out     = {32'hA5C3_3C5A, 32'h0F69_96F0};
      port_ctl       = {10'h2AA, 10'h155};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_values();
      t_readback();
      t_input_route();
      t_output_route();
      give_verdict();
   end
endmodule
